// [rtl/otsc_clock_out_divide.sv]
`timescale 1ns/100ps
module otsc_clock_out_divide (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       en_i,
	input  wire logic       tick_i,
	input  wire logic [4:0] div_i,
	// Pin level
	output logic            clk_o
);
	logic [4:0] cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i || !en_i) begin
			cnt   <= 5'h00;
			clk_o <= 1'b0;
		end else if (tick_i) begin
			if (cnt >= div_i) begin
				cnt   <= 5'h00;
				clk_o <= ~clk_o;
			end else begin
				cnt <= cnt + 5'h01;
			end
		end
	end

	held_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!en_i |=> clk_o == 1'b0 && cnt == 5'h00)
		else $error("clock output not held low while disabled");

	divide_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(en_i && tick_i && cnt < div_i) |=> clk_o == $past(clk_o) && cnt == $past(cnt) + 5'h01)
		else $error("clock output toggled early");

endmodule

// [rtl/otsc_pkg.sv]
package otsc_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_COARSE = 16'hA001;
	localparam logic [15:0] IDX_FINE   = 16'hA002;
	localparam logic [15:0] IDX_CLOCK_OUTPUT_CONTROL = 16'hA006;
	localparam logic [15:0] IDX_SLOW   = 16'hA007;
	localparam logic [15:0] IDX_STATUS = 16'hA008;

	// ----------------------------------------------------------------
	// Reset values and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_COARSE   = 8'h01;
	localparam logic [7:0] RST_FINE     = 8'h80;
	localparam logic [7:0] RST_CLOCK_OUTPUT_CONTROL   = 8'h00;
	localparam logic [4:0] RST_SLOW     = 5'h08;
	localparam int         RATE_LSB     = 4;
	localparam int         AMP_LSB      = 2;
	localparam int         CO_EN_BIT    = 7;
	localparam int         CO_SEL_LSB   = 5;
	localparam int         SLOW_SEL_BIT = 4;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] SRC_FAST    = 2'h1;
	localparam logic [1:0] SRC_LOW     = 2'h2;
	localparam logic [3:0] DIV_128K    = 4'h4;
	localparam logic [3:0] DIV_256K    = 4'h8;
	localparam logic [7:0] CODE_MAX    = 8'hFF;
	localparam logic [6:0] PEAK_BASE   = 7'h04;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] SEL_NONE    = 3'h0;
	localparam logic [2:0] SEL_COARSE  = 3'h1;
	localparam logic [2:0] SEL_FINE    = 3'h2;
	localparam logic [2:0] SEL_CLOCK_OUTPUT_CONTROL  = 3'h3;
	localparam logic [2:0] SEL_SLOW    = 3'h4;
	localparam logic [2:0] SEL_STATUS  = 3'h5;

	typedef enum logic [2:0] {
		SW_IDLE = 3'h1,
		SW_UP   = 3'h2,
		SW_DOWN = 3'h4
	} otsc_sweep_t;

	function automatic logic [6:0] otsc_peak(input logic [1:0] amp);
		otsc_peak = PEAK_BASE << amp;
	endfunction

	function automatic logic [2:0] otsc_decode(input logic [19:0] addr);
		if (addr == {2'h0, IDX_COARSE, 2'h0})
			otsc_decode = SEL_COARSE;
		else if (addr == {2'h0, IDX_FINE, 2'h0})
			otsc_decode = SEL_FINE;
		else if (addr == {2'h0, IDX_CLOCK_OUTPUT_CONTROL, 2'h0})
			otsc_decode = SEL_CLOCK_OUTPUT_CONTROL;
		else if (addr == {2'h0, IDX_SLOW, 2'h0})
			otsc_decode = SEL_SLOW;
		else if (addr == {2'h0, IDX_STATUS, 2'h0})
			otsc_decode = SEL_STATUS;
		else
			otsc_decode = SEL_NONE;
	endfunction

endpackage

// [rtl/otsc_sweep.sv]
`timescale 1ns/100ps
module otsc_sweep (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Fast oscillator rising edge
	input  wire logic       tick_i,
	// Settings
	input  wire logic [3:0] rate_i,
	input  wire logic [1:0] amp_i,
	input  wire logic [7:0] fine_i,
	// Oscillator code
	output logic      [7:0] code_o,
	output logic            active_o
);
	logic [3:0]               cnt;
	logic                     half;
	logic signed [6:0]        off;
	otsc_pkg::otsc_sweep_t    state;

	wire signed [6:0] peak   = $signed(otsc_pkg::otsc_peak(amp_i));
	wire              upd    = tick_i && (state != otsc_pkg::SW_IDLE) && (cnt >= rate_i - 4'h1);
	wire              at_top = off >= peak;
	wire              at_bot = off <= -peak;
	wire signed [9:0] sum    = $signed({2'h0, fine_i}) + $signed({{3{off[6]}}, off});
	// Clip rather than wrap: a wrap would jump the oscillator end to end
	wire [7:0] next_code = (sum < 0) ? 8'h00 : (sum > 10'sd255) ? otsc_pkg::CODE_MAX
		: sum[7:0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state    <= otsc_pkg::SW_IDLE;
			cnt      <= 4'h0;
			half     <= 1'b0;
			off      <= 7'sd0;
			code_o   <= otsc_pkg::RST_FINE;
			active_o <= 1'b0;
		end else begin
			code_o   <= next_code;
			active_o <= state != otsc_pkg::SW_IDLE;
			if (rate_i == 4'h0) begin
				state <= otsc_pkg::SW_IDLE;
				cnt   <= 4'h0;
				half  <= 1'b0;
				off   <= 7'sd0;
			end else begin
				if (tick_i)
					cnt <= (cnt >= rate_i - 4'h1) ? 4'h0 : cnt + 4'h1;
				// Each code dwells two updates, the two ends four, for a 4*rate*(2A+1) period
				case (state)
					otsc_pkg::SW_IDLE: begin
						state <= otsc_pkg::SW_UP;
					end
					otsc_pkg::SW_UP: begin
						if (upd) begin
							half <= ~half;
							if (half && at_top)
								state <= otsc_pkg::SW_DOWN;
							else if (half)
								off <= off + 7'sd1;
						end
					end
					otsc_pkg::SW_DOWN: begin
						if (upd) begin
							half <= ~half;
							if (half && at_bot)
								state <= otsc_pkg::SW_UP;
							else if (half)
								off <= off - 7'sd1;
						end
					end
					default: begin
						state <= otsc_pkg::SW_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence rate_zero_s;
		(rate_i == 4'h0) [*2];
	endsequence

	fixed_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rate_zero_s |=> code_o == $past(fine_i))
		else $error("code differs from fine trim with sweep off");

	clip_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(sum > 10'sd255) |=> code_o == otsc_pkg::CODE_MAX)
		else $error("swept code not clipped at top");

	update_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(upd && rate_i >= 4'h2 && $stable(rate_i)) |=> !upd)
		else $error("offset updates too close together");

	peak_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == otsc_pkg::SW_UP && upd && half && off == peak && rate_i != 4'h0)
		|=> off == $past(off) && state == otsc_pkg::SW_DOWN)
		else $error("offset passed the peak");

	step_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(rate_i != 4'h0 && $past(rate_i) != 4'h0) |->
		(off - $past(off) <= 7'sd1) && ($past(off) - off <= 7'sd1))
		else $error("offset skipped a code");

endmodule

// [rtl/otsc_top.sv]
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
// Behaviour
// - Sweep rate zero passes fine trim unchanged
// - Amplitude code selects peak 4/8/16/32
// - Swept code is trim plus offset, clipped
// - Rate sets fast cycles per offset update
// - Coarse and fine trim drive the oscillator
// - Fast oscillator stops in stop/sleep
// - Slow oscillator is never powered down
// - Select bit picks 256k or 128k centre
// - Low trim nibble goes to slow oscillator
// - Divider keeps low-speed clock near 32k
// - Enable bit gates the clock-output divider
// - Source select: system, fast, 32k, system
// - Output is fast or 32k source over divide plus one, system clock over twice that
module otsc_top (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// AXI4-Lite write address
	input  wire logic [19:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [19:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Oscillator clocks seen as pins
	input  wire logic        fast_osc_clk_i,
	input  wire logic        low_speed_32k_clk_i,
	// Processor power modes
	input  wire logic        stop_mode_i,
	input  wire logic        sleep_mode_i,
	// Fast oscillator controls
	output logic [1:0]       coarse_trim_o,
	output logic [7:0]       swept_trim_output_o,
	output logic             fast_osc_enable_o,
	// Slow oscillator controls
	output logic             slow_osc_power_o,
	output logic [3:0]       slow_trim_o,
	output logic             slow_high_256k_o,
	output logic [3:0]       low_speed_div_o,
	// Clock output pin
	output logic             clock_out_o
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] coarse_trim_spread_reg;
	logic [7:0] fine_trim_value;
	logic [7:0] clock_output_reg;
	logic [4:0] slow_trim_reg;
	logic       sweep_active;

	// ----------------------------------------------------------------
	// Pin synchronisers: bit 0 fast oscillator, bit 1 32k clock
	// ----------------------------------------------------------------
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] sync3;
	logic [1:0] lvl;

	wire [1:0] agree     = ~(sync2 ^ sync3);
	wire [1:0] change    = agree & (sync2 ^ lvl);
	wire [1:0] next_lvl  = (agree & sync2) | (~agree & lvl);
	wire       fast_rise = change[0] & sync2[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= 2'h0;
			sync2 <= 2'h0;
			sync3 <= 2'h0;
			lvl   <= 2'h0;
		end else begin
			sync1 <= {low_speed_32k_clk_i, fast_osc_clk_i};
			sync2 <= sync1;
			sync3 <= sync2;
			lvl   <= next_lvl;
		end
	end

	// ----------------------------------------------------------------
	// Field views
	// ----------------------------------------------------------------
	wire [3:0] sweep_rate       = coarse_trim_spread_reg[otsc_pkg::RATE_LSB +: 4];
	wire [1:0] sweep_amplitude  = coarse_trim_spread_reg[otsc_pkg::AMP_LSB +: 2];
	wire       clock_out_enable = clock_output_reg[otsc_pkg::CO_EN_BIT];
	wire [1:0] clock_out_source = clock_output_reg[otsc_pkg::CO_SEL_LSB +: 2];
	wire [4:0] clock_out_divide = clock_output_reg[4:0];

	assign coarse_trim_o    = coarse_trim_spread_reg[1:0];
	assign slow_trim_o      = slow_trim_reg[3:0];
	assign slow_high_256k_o = slow_trim_reg[otsc_pkg::SLOW_SEL_BIT];

	// Code 11 has no source of its own and falls back to the system clock
	wire src_tick = (clock_out_source == otsc_pkg::SRC_FAST) ? change[0]
		: (clock_out_source == otsc_pkg::SRC_LOW) ? change[1] : 1'b1;

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	logic        aw_held;
	logic [19:0] aw_addr_q;
	logic        w_held;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;

	wire        aw_hs       = s_axi_awvalid & s_axi_awready;
	wire        w_hs        = s_axi_wvalid & s_axi_wready;
	wire        have_aw     = aw_held | aw_hs;
	wire        have_w      = w_held | w_hs;
	wire        wr_fire     = have_aw & have_w & ~s_axi_bvalid;
	wire [19:0] wr_addr     = aw_held ? aw_addr_q : s_axi_awaddr;
	wire [31:0] wr_data     = w_held ? w_data_q : s_axi_wdata;
	wire [3:0]  wr_strb     = w_held ? w_strb_q : s_axi_wstrb;
	wire [2:0]  wr_sel      = otsc_pkg::otsc_decode(wr_addr);
	wire        wr_en       = wr_fire & wr_strb[0];
	wire        next_aw     = have_aw & ~wr_fire;
	wire        next_w      = have_w & ~wr_fire;
	wire        next_bvalid = wr_fire | (s_axi_bvalid & ~s_axi_bready);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr_q     <= 20'h00000;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= otsc_pkg::RESP_OKAY;
		end else begin
			aw_held       <= next_aw;
			w_held        <= next_w;
			s_axi_awready <= ~next_aw & ~next_bvalid;
			s_axi_wready  <= ~next_w & ~next_bvalid;
			s_axi_bvalid  <= next_bvalid;
			if (aw_hs)
				aw_addr_q <= s_axi_awaddr;
			if (w_hs) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire)
				s_axi_bresp <= (wr_sel == otsc_pkg::SEL_NONE) ? otsc_pkg::RESP_SLVERR
					: otsc_pkg::RESP_OKAY;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			coarse_trim_spread_reg <= otsc_pkg::RST_COARSE;
			fine_trim_value        <= otsc_pkg::RST_FINE;
			clock_output_reg       <= otsc_pkg::RST_CLOCK_OUTPUT_CONTROL;
			slow_trim_reg          <= otsc_pkg::RST_SLOW;
		end else if (wr_en) begin
			if (wr_sel == otsc_pkg::SEL_COARSE)
				coarse_trim_spread_reg <= wr_data[7:0];
			if (wr_sel == otsc_pkg::SEL_FINE)
				fine_trim_value <= wr_data[7:0];
			// Source is not re-timed on change; a glitch-free switch relies on
			// software turning the output off first
			if (wr_sel == otsc_pkg::SEL_CLOCK_OUTPUT_CONTROL)
				clock_output_reg <= wr_data[7:0];
			if (wr_sel == otsc_pkg::SEL_SLOW)
				slow_trim_reg <= wr_data[4:0];
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	wire        ar_hs       = s_axi_arvalid & s_axi_arready;
	wire [2:0]  rd_sel      = otsc_pkg::otsc_decode(s_axi_araddr);
	wire        next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);
	wire [31:0] rd_word     =
		(rd_sel == otsc_pkg::SEL_COARSE) ? {24'h000000, coarse_trim_spread_reg} :
		(rd_sel == otsc_pkg::SEL_FINE)   ? {24'h000000, fine_trim_value} :
		(rd_sel == otsc_pkg::SEL_CLOCK_OUTPUT_CONTROL) ? {24'h000000, clock_output_reg} :
		(rd_sel == otsc_pkg::SEL_SLOW)   ? {27'h0000000, slow_trim_reg} :
		(rd_sel == otsc_pkg::SEL_STATUS) ? {22'h000000, fast_osc_enable_o, sweep_active,
			swept_trim_output_o} : 32'h00000000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= otsc_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= ~next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			if (ar_hs) begin
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (rd_sel == otsc_pkg::SEL_NONE) ? otsc_pkg::RESP_SLVERR
					: otsc_pkg::RESP_OKAY;
			end
		end
	end

	// ----------------------------------------------------------------
	// Oscillator power and slow divider
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_osc_enable_o <= 1'b1;
			slow_osc_power_o  <= 1'b1;
			low_speed_div_o   <= otsc_pkg::DIV_128K;
		end else begin
			fast_osc_enable_o <= ~(stop_mode_i | sleep_mode_i);
			slow_osc_power_o  <= 1'b1;
			// Twice the centre frequency needs twice the division
			low_speed_div_o   <= slow_trim_reg[otsc_pkg::SLOW_SEL_BIT] ? otsc_pkg::DIV_256K
				: otsc_pkg::DIV_128K;
		end
	end

	// ----------------------------------------------------------------
	// Sweep and clock output
	// ----------------------------------------------------------------
	otsc_sweep u_sweep (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.tick_i   (fast_rise),
		.rate_i   (sweep_rate),
		.amp_i    (sweep_amplitude),
		.fine_i   (fine_trim_value),
		.code_o   (swept_trim_output_o),
		.active_o (sweep_active)
	);

	otsc_clock_out_divide u_clock_out_divide (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.en_i   (clock_out_enable),
		.tick_i (src_tick),
		.div_i  (clock_out_divide),
		.clk_o  (clock_out_o)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	osc_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(stop_mode_i || sleep_mode_i) |=> !fast_osc_enable_o)
		else $error("fast oscillator left running in low power mode");

	slow_power_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> slow_osc_power_o)
		else $error("slow oscillator powered down");

	slow_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(slow_high_256k_o && $stable(slow_trim_reg)) |=> low_speed_div_o == otsc_pkg::DIV_256K)
		else $error("slow divider not doubled for 256k centre");

	fine_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && wr_sel == otsc_pkg::SEL_FINE && sweep_rate == 4'h0) ##1 (sweep_rate == 4'h0)
		|=> swept_trim_output_o == $past(fine_trim_value))
		else $error("written fine trim not seen by oscillator");

	write_resp_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_fire |=> s_axi_bvalid && s_axi_bresp == (($past(wr_sel) == otsc_pkg::SEL_NONE)
			? otsc_pkg::RESP_SLVERR : otsc_pkg::RESP_OKAY))
		else $error("write response wrong");

	// Coarse and slow trim writes reach the oscillator controls on the next cycle
	sequence slow_wr_s;
		wr_en && wr_sel == otsc_pkg::SEL_SLOW;
	endsequence

	sequence coarse_wr_s;
		wr_en && wr_sel == otsc_pkg::SEL_COARSE;
	endsequence

	slow_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		slow_wr_s |=> {slow_high_256k_o, slow_trim_o} == $past(wr_data[4:0]))
		else $error("slow trim write not seen by slow oscillator");

	coarse_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		coarse_wr_s |=> coarse_trim_o == $past(wr_data[1:0]))
		else $error("coarse trim write not seen by fast oscillator");

	// Codes 00 and 11 both count every system clock
	sys_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(clock_out_source != otsc_pkg::SRC_FAST && clock_out_source != otsc_pkg::SRC_LOW)
		|-> src_tick)
		else $error("system clock source not selected");

	fast_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(clock_out_source == otsc_pkg::SRC_FAST) |-> src_tick == change[0])
		else $error("fast oscillator source not selected");

	low_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(clock_out_source == otsc_pkg::SRC_LOW) |-> src_tick == change[1])
		else $error("low-speed clock source not selected");

endmodule

// [testbench/otsc_osc_model.sv]
`timescale 1ns/100ps
module otsc_osc_model #(
	parameter real FAST_HALF = 12.3,
	parameter real SLOW_PER  = 20.0
) (
	// Controls from the block
	input  wire logic       fast_en_i,
	input  wire logic       slow_pwr_i,
	input  wire logic       high_256k_i,
	input  wire logic [3:0] ls_div_i,
	// Oscillator levels
	output logic            fast_clk_o,
	output logic            ls_clk_o
);
	real ls_half;

	initial begin
		fast_clk_o = 1'b0;
		ls_clk_o   = 1'b0;
	end

	// A stopped oscillator freezes in place and shows no edges at all
	always begin
		#(FAST_HALF);
		if (fast_en_i) begin
			fast_clk_o = ~fast_clk_o;
		end
	end

	// 256k centring halves the core period; only the divider brings 32k back
	always begin
		ls_half = (high_256k_i ? SLOW_PER / 2.0 : SLOW_PER) * ls_div_i / 2.0;
		#((ls_half > 0.0) ? ls_half : 1.0);
		if (slow_pwr_i) begin
			ls_clk_o = ~ls_clk_o;
		end
	end
endmodule

// [testbench/tb.sv]
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
	localparam real FH = 12.3;
	localparam real SP = 20.0;
	localparam logic [15:0] IDX [4] = '{otsc_pkg::IDX_COARSE, otsc_pkg::IDX_FINE,
		otsc_pkg::IDX_CLOCK_OUTPUT_CONTROL, otsc_pkg::IDX_SLOW};
	localparam logic [7:0] RSTV [4] = '{8'h01, 8'h80, 8'h00, 8'h08};
	localparam logic [7:0] MSK [4]  = '{8'hFF, 8'hFF, 8'hFF, 8'h1F};

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [19:0] awa = '0;
	logic [19:0] ara = '0;
	logic [31:0] wd = '0;
	logic [31:0] rdt;
	logic [31:0] d;
	logic [1:0]  br, rr, r, coarse;
	logic        awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
	logic        awr, wrd, bv, arr, rv;
	logic        stop = 1'b0, sleep = 1'b0;
	logic        fclk, lclk, fen, spwr, hi, cko;
	logic [7:0]  sw;
	logic [3:0]  strim, ldiv;
	int          n_fail = 0;
	int          n_tests = 0;

	always #2.5 clk_i = ~clk_i;

	otsc_top dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd),
		.fast_osc_clk_i(fclk), .low_speed_32k_clk_i(lclk),
		.stop_mode_i(stop), .sleep_mode_i(sleep),
		.coarse_trim_o(coarse), .swept_trim_output_o(sw), .fast_osc_enable_o(fen),
		.slow_osc_power_o(spwr), .slow_trim_o(strim), .slow_high_256k_o(hi),
		.low_speed_div_o(ldiv), .clock_out_o(cko));

	otsc_osc_model #(.FAST_HALF(FH), .SLOW_PER(SP)) osc_u (.fast_en_i(fen),
		.slow_pwr_i(spwr), .high_256k_i(hi), .ls_div_i(ldiv),
		.fast_clk_o(fclk), .ls_clk_o(lclk));

	// ----------------------------------------------------------------
	// Bus tasks and helpers
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic hang();
		n_fail++;
		$display("mismatch wait_bound exp 1 got 0");
		conclude();
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] v, output logic [1:0] s);
		int n;
		@(posedge clk_i);
		awa <= {2'h0, idx, 2'h0};
		wd  <= {24'h0, v};
		awv <= 1'b1;
		wv  <= 1'b1;
		brd <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end while (!bv && n < 200);
		s = br;
		brd <= 1'b0;
		if (n >= 200) hang();
	endtask

	task automatic rd(input logic [15:0] idx, output logic [31:0] q, output logic [1:0] s);
		int n;
		@(posedge clk_i);
		ara <= {2'h0, idx, 2'h0};
		arv <= 1'b1;
		rrd <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			if (arr) arv <= 1'b0;
		end while (!rv && n < 200);
		q = rdt;
		s = rr;
		rrd <= 1'b0;
		if (n >= 200) hang();
	endtask

	task automatic rise();
		int n;
		logic p;
		n = 0;
		p = cko;
		@(posedge clk_i);
		while (!(cko && !p) && n < 4000) begin
			p = cko;
			@(posedge clk_i);
			n++;
		end
		if (n >= 4000) hang();
	endtask

	function automatic real pin_ns(input logic [1:0] src, input logic [4:0] div);
		return (src == 2'h1 ? 2.0 * FH : src == 2'h2 ? 4.0 * SP : 10.0) * (div + 1);
	endfunction

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic sweep(input logic [1:0] amp, input logic [7:0] fine, input logic [3:0] rate);
		int a, lo, up, hits;
		logic [7:0] mn, mx, prev;
		realtime t0, dt;
		a = 4 << amp;
		lo = (fine < a) ? 0 : fine - a;
		up = (fine + a > 255) ? 255 : fine + a;
		mn = 8'hFF;
		mx = 8'h00;
		hits = 0;
		t0 = 0;
		dt = 0;
		wr(otsc_pkg::IDX_COARSE, 8'h02, r);
		wr(otsc_pkg::IDX_FINE, fine, r);
		wr(otsc_pkg::IDX_COARSE, {rate, amp, 2'h2}, r);
		cyc(4);
		prev = sw;
		repeat (2200) begin
			@(posedge clk_i);
			`CHK("sweep_step", 1'b1, sw - prev == 8'h01 || prev - sw == 8'h01 || sw == prev)
			if (sw < mn) mn = sw;
			if (sw > mx) mx = sw;
			if (sw == 8'(up) && prev != 8'(up)) begin
				hits++;
				if (hits == 1) t0 = $realtime;
				if (hits == 2) dt = $realtime - t0;
			end
			prev = sw;
		end
		`CHK("sweep_min", 8'(lo), mn)
		`CHK("sweep_max", 8'(up), mx)
		dt = dt - 8.0 * FH * rate * (2 * a + 1);
		`CHK("sweep_period", 1'b1, dt <= 11.0 && dt >= -11.0)
	endtask

	task automatic clko(input logic [1:0] src, input logic [4:0] div);
		realtime t0, dt;
		wr(otsc_pkg::IDX_CLOCK_OUTPUT_CONTROL, 8'h00, r); // disable before a source change
		cyc(20);
		`CHK("pin_idle", 1'b0, cko)
		wr(otsc_pkg::IDX_CLOCK_OUTPUT_CONTROL, {1'b1, src, div}, r);
		rise();
		t0 = $realtime;
		rise();
		dt = $realtime - t0 - pin_ns(src, div);
		`CHK("pin_period", 1'b1, dt <= 11.0 && dt >= -11.0)
	endtask

	initial begin
		int i;
		logic [7:0] v;
		void'($urandom(32'ha471));
		cyc(8);
		rst_i <= 1'b0;
		cyc(2);
		`CHK("coarse_rst", 2'h1, coarse)
		`CHK("swept_rst", 8'h80, sw)
		`CHK("slow_pwr", 1'b1, spwr)
		`CHK("slow_trim_rst", 4'h8, strim)
		`CHK("slow_sel_rst", 1'b0, hi)
		`CHK("pin_rst", 1'b0, cko)
		for (i = 0; i < 4; i++) begin
			rd(IDX[i], d, r);
			`CHK("reg_rst", {24'h0, RSTV[i]}, d)
		end
		for (i = 0; i < 16; i++) begin
			v = 8'($urandom);
			if (i % 4 == 2) wr(otsc_pkg::IDX_CLOCK_OUTPUT_CONTROL, 8'h00, r); // output off first
			wr(IDX[i % 4], v, r);
			`CHK("wresp", otsc_pkg::RESP_OKAY, r)
			rd(IDX[i % 4], d, r);
			`CHK("reg_rw", {24'h0, v & MSK[i % 4]}, d)
			if (i % 4 == 0) `CHK("coarse", v[1:0], coarse)
			if (i % 4 == 3) begin
				`CHK("slow_trim", v[3:0], strim)
				`CHK("slow_sel", v[4], hi)
				`CHK("ls_div", v[4] ? 4'h8 : 4'h4, ldiv)
			end
		end
		wr(16'hA003, 8'h55, r);
		`CHK("unmapped_w", otsc_pkg::RESP_SLVERR, r)
		rd(16'hA003, d, r);
		`CHK("unmapped_r", otsc_pkg::RESP_SLVERR, r)
		`CHK("unmapped_d", 32'h0, d)
		wr(otsc_pkg::IDX_STATUS, 8'hFF, r);
		`CHK("status_w", otsc_pkg::RESP_OKAY, r)
		v = 8'($urandom);
		wr(otsc_pkg::IDX_COARSE, 8'h0E, r);
		wr(otsc_pkg::IDX_FINE, v, r);
		cyc(4);
		`CHK("fixed_code", v, sw)
		rd(otsc_pkg::IDX_STATUS, d, r);
		`CHK("status", {2'h2, v}, d[9:0])
		stop <= 1'b1;
		cyc(2);
		`CHK("stop_osc", 1'b0, fen)
		stop <= 1'b0;
		sleep <= 1'b1;
		cyc(2);
		`CHK("sleep_osc", 1'b0, fen)
		sleep <= 1'b0;
		cyc(2);
		`CHK("wake_osc", 1'b1, fen)
		sweep(2'h0, 8'h80, 4'h3);
		sweep(2'h1, 8'h80, 4'h1);
		sweep(2'h2, 8'(16 + $urandom % 224), 4'h2); // trim kept unclipped
		sweep(2'h3, 8'h02, 4'h1);
		sweep(2'h2, 8'hF8, 4'h1);
		wr(otsc_pkg::IDX_SLOW, 8'h08, r);
		clko(2'h0, 5'h00);
		for (i = 1; i < 4; i++) clko(2'(i), 5'($urandom));
		wr(otsc_pkg::IDX_SLOW, 8'h18, r);
		clko(2'h2, 5'h03);
		wr(otsc_pkg::IDX_CLOCK_OUTPUT_CONTROL, 8'h00, r);
		cyc(20);
		`CHK("pin_off", 1'b0, cko)
		conclude();
	end
endmodule
